// file: core/flash_loader_pkg.sv
// constants and types for the serial flash configuration loader
// Functional notes
// RULE_01 - variant select inputs are captured when the init indicator goes high
// RULE_02 - read command then start address shifted out toward the flash
// RULE_03 - bitstream captured serially from the flash data line
// RULE_04 - after loading, user logic deselects the flash or keeps using it
// RULE_05 - config clock made from internal clock, rate set by an option
// RULE_06 - after own load, chain data forwarded on falling config clock edges
// RULE_07 - init pulled low while clearing, released when clearing ends
// RULE_08 - slow flash: outside logic holds init low until flash is awake
// RULE_09 - init driven low on a CRC error in the bitstream
// RULE_10 - completion pin low during load, released only on success
// RULE_11 - reprogram low for 500 ns or more restarts after it rises again
// RULE_12 - no configuration start while reprogram is low
// RULE_13 - reprogram low floats all pins, pullups unless pullup select high; par_address_o stays driven
// RULE_14 - flash-side device strapped mode 001, downstream devices mode 111
// RULE_15 - completion release cycle must be 5 or earlier; default 4
// RULE_16 - parallel mode: address from 0 up, or from 0xFF_FFFF down
// RULE_17 - with lock wait set, user mode waits for every selected lock
// RULE_18 - an option picks which of six startup cycles stalls for lock
// RULE_19 - a clock manager lock is high only while its clocks are aligned
// RULE_20 - serial output msb first, changed on falling config clock edge
package flash_loader_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LENGTH = 8'h04;
  localparam logic [7:0] OFS_COMMAND = 8'h08;
  localparam logic [7:0] OFS_CRC = 8'h0C;
  localparam logic [7:0] OFS_LOCK_MASK = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PAR_ADDR = 8'h18;
  localparam logic [7:0] OFS_SHIFT_WORD = 8'h1C;
  // control fields
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_STALL_LSB = 8;
  localparam int CTRL_DONE_LSB = 11;
  localparam int CTRL_PAR_BIT = 14;
  localparam int CTRL_CHAIN_BIT = 15;
  localparam int CTRL_CRC_BIT = 16;
  localparam int CTRL_RESTART_BIT = 17;
  localparam logic [31:0] CTRL_RESET = 32'h0001_2504;
  localparam logic [31:0] LENGTH_RESET = 32'h0000_0400;
  localparam logic [31:0] COMMAND_RESET = 32'h0300_0000;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_MIN_NS = 500;
  localparam int PROG_MIN_CYC = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] MIN_HALF_PERIOD = 8'h04;
  localparam logic [2:0] LAST_STARTUP_CYCLE = 3'h5;
  localparam int CMD_ADDR_BITS = 32;
  // parallel addressing, crc and bus responses
  localparam logic [23:0] PAR_ADDR_UP_START = 24'h00_0000;
  localparam logic [23:0] PAR_ADDR_DOWN_START = 24'hFF_FFFF;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_HOLD = 4'b0000,
    ST_CLEAR = 4'b0001,
    ST_WAIT_INIT = 4'b0010,
    ST_COMMAND = 4'b0011,
    ST_LOAD = 4'b0100,
    ST_CHECK = 4'b0101,
    ST_STARTUP = 4'b0110,
    ST_USER = 4'b0111,
    ST_ERROR = 4'b1000
  } load_state_e;

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic bit_in);
    crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ bit_in) ? CRC_POLY : 16'h0000);
  endfunction
endpackage

// file: core/pin_sync.sv
// three-stage input synchroniser, changes once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // pins
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level_o);

  initial
  begin
    if (WIDTH < 1) $error("pin_sync width must be positive");
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level_o <= '0;
    end
    else
    begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level_o <= next_level;
    end
  end
endmodule // pin_sync

// file: core/serial_flash_config_loader.sv
// configuration loader from serial flash, with axi4-lite control registers
`timescale 1ns/100ps
module serial_flash_config_loader
  import flash_loader_pkg::*;
#(
  parameter int LOCK_COUNT = 4,
  parameter int CLEAR_CYCLES = 64
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // flash link
  output logic flash_select_n_o,
  output logic flash_select_oe_n_o,
  output logic config_clock_o,
  output logic config_clock_oe_n_o,
  output logic flash_cmd_o,
  output logic flash_cmd_oe_n_o,
  input wire logic flash_data_i,
  output logic chain_data_o,
  output logic chain_data_oe_n_o,
  output logic [23:0] par_address_o,
  // configuration pins
  input wire logic reprogram_n_i,
  input wire logic pullup_disable_select_i,
  input wire logic [2:0] variant_select_i,
  input wire logic address_direction_pin_i,
  input wire logic init_n_i,
  output logic init_n_o,
  output logic init_oe_n_o,
  input wire logic done_i,
  output logic done_o,
  output logic done_oe_n_o,
  output logic pullups_on_o,
  // clock manager locks
  input wire logic [LOCK_COUNT-1:0] clock_manager_locked_i
);
  localparam int SYNC_W = LOCK_COUNT + 8;

  initial
  begin
    if (LOCK_COUNT < 1 || LOCK_COUNT > 32) $error("LOCK_COUNT must be 1..32");
    if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 65535) $error("CLEAR_CYCLES out of range");
  end

  // synchronised pins
  logic [SYNC_W-1:0] synced;
  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i({clock_manager_locked_i, done_i, init_n_i, address_direction_pin_i,
            variant_select_i, flash_data_i, reprogram_n_i}),
    .level_o(synced)
  );
  wire reprog_n = synced[0];
  wire data_in = synced[1];
  wire [2:0] variant_pin = synced[4:2];
  wire dir_pin = synced[5];
  wire init_pin = synced[6];
  wire done_pin = synced[7];
  wire [LOCK_COUNT-1:0] locks = synced[SYNC_W-1:8];

  // registers
  logic [31:0] ctrl;
  logic [31:0] length;
  logic [31:0] command;
  logic [15:0] crc_expect;
  logic [LOCK_COUNT-1:0] lock_mask;
  load_state_e state;
  load_state_e next_state;
  logic [15:0] count;
  logic [31:0] shift_out;
  logic [31:0] shift_in;
  logic [15:0] crc;
  logic crc_error;
  logic [2:0] variant;
  logic addr_dir;
  logic [2:0] stage;
  logic done_released;
  logic [7:0] div_count;
  logic clk_level;
  logic [6:0] low_count;
  logic restart_armed;
  logic prev_init_pin;

  // axi write and read channel state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic ar_pending;
  logic [7:0] ar_addr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = strb[i] ? val[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr[1:0] == 2'b00) && (addr <= OFS_SHIFT_WORD);
  endfunction

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
  wire w_take = s_axi_wvalid_i && s_axi_wready_o;
  wire do_write = aw_held && w_held && !s_axi_bvalid_o;
  wire wr_ctrl = do_write && aw_addr == OFS_CTRL;
  wire sw_restart = wr_ctrl && w_strb[2] && w_data[CTRL_RESTART_BIT];

  // control fields
  wire [7:0] rate_field = ctrl[CTRL_RATE_LSB +: 8];
  wire [7:0] half_period = (rate_field < MIN_HALF_PERIOD) ? MIN_HALF_PERIOD : rate_field;
  wire [2:0] stall_cycle = ctrl[CTRL_STALL_LSB +: 3];
  wire [2:0] done_cycle = ctrl[CTRL_DONE_LSB +: 3];
  wire par_mode = ctrl[CTRL_PAR_BIT];
  wire chain_en = ctrl[CTRL_CHAIN_BIT];
  wire crc_en = ctrl[CTRL_CRC_BIT];

  // config clock divider; events mark the edges this cycle produces
  wire clk_run = (state == ST_COMMAND) || (state == ST_LOAD) || (state == ST_STARTUP) ||
                 (state == ST_USER && chain_en); // see RULE_05
  wire div_wrap = clk_run && (div_count == half_period - 8'd1);
  wire rise_ev = div_wrap && !clk_level;
  wire fall_ev = div_wrap && clk_level;

  // reprogram pulse filter
  wire prog_low = !reprog_n;
  wire prog_done = restart_armed && reprog_n; // see RULE_11
  wire init_rise = init_pin && !prev_init_pin;
  wire locks_ok = &(locks | ~lock_mask); // see RULE_19
  wire stall = (lock_mask != '0) && (stage == stall_cycle) && !locks_ok; // see RULE_17
  wire [15:0] len_last = length[15:0] - 16'd1;
  wire crc_bad = crc_en && (crc != crc_expect);

  always_comb
  begin
    next_state = state;
    case (state)
      ST_HOLD: if (reprog_n) next_state = ST_CLEAR; // see RULE_12
      ST_CLEAR: if (count == 16'(CLEAR_CYCLES - 1)) next_state = ST_WAIT_INIT;
      ST_WAIT_INIT: if (init_rise) next_state = par_mode ? ST_LOAD : ST_COMMAND;
      ST_COMMAND: if (fall_ev && count == 16'(CMD_ADDR_BITS - 1)) next_state = ST_LOAD;
      ST_LOAD: if (fall_ev && count == len_last) next_state = ST_CHECK;
      ST_CHECK: next_state = crc_bad ? ST_ERROR : ST_STARTUP;
      ST_STARTUP: if (rise_ev && !stall && stage == LAST_STARTUP_CYCLE) next_state = ST_USER;
      ST_USER: next_state = ST_USER;
      ST_ERROR: next_state = ST_ERROR;
      default: next_state = ST_HOLD;
    endcase
    if (prog_low || prog_done || sw_restart) next_state = ST_HOLD;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_HOLD;
      count <= '0;
      prev_init_pin <= 1'b0;
      low_count <= '0;
      restart_armed <= 1'b0;
    end
    else
    begin
      state <= next_state;
      prev_init_pin <= init_pin;
      low_count <= prog_low ? ((low_count == 7'(PROG_MIN_CYC)) ? low_count : low_count + 7'd1)
                            : '0;
      if (prog_low && low_count == 7'(PROG_MIN_CYC - 1)) restart_armed <= 1'b1; // see RULE_11
      else if (reprog_n) restart_armed <= 1'b0;
      if (next_state != state) count <= '0;
      else if (state == ST_CLEAR || ((state == ST_COMMAND || state == ST_LOAD) && fall_ev))
        count <= count + 16'd1;
    end
  end

  // clock divider and serial datapath
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !clk_run)
    begin
      div_count <= '0;
      clk_level <= 1'b0;
    end
    else
    begin
      div_count <= div_wrap ? 8'd0 : div_count + 8'd1;
      clk_level <= div_wrap ? !clk_level : clk_level;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      shift_out <= '0;
      shift_in <= '0;
      crc <= CRC_SEED;
      chain_data_o <= 1'b0;
      variant <= '0;
      addr_dir <= 1'b0;
      par_address_o <= PAR_ADDR_UP_START;
    end
    else
    begin
      if (state == ST_WAIT_INIT && init_rise)
      begin
        variant <= variant_pin; // see RULE_01
        addr_dir <= dir_pin;
        shift_out <= command; // see RULE_02
        crc <= CRC_SEED;
        par_address_o <= dir_pin ? PAR_ADDR_DOWN_START : PAR_ADDR_UP_START; // see RULE_16
      end
      else if (state == ST_COMMAND && fall_ev)
        shift_out <= {shift_out[30:0], 1'b0}; // see RULE_20
      if (state == ST_LOAD && fall_ev)
      begin
        // flash drives on falling edge, so its bit is stable at the end of high phase
        shift_in <= {shift_in[30:0], data_in}; // see RULE_03
        crc <= crc_step(crc, data_in);
        if (par_mode)
          par_address_o <= addr_dir ? par_address_o - 24'd1 : par_address_o + 24'd1;
      end
      if (state == ST_USER && chain_en && fall_ev)
        chain_data_o <= data_in; // see RULE_06
    end
  end

  // startup sequence and status flags
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || state == ST_HOLD)
    begin
      stage <= '0;
      done_released <= 1'b0;
      crc_error <= 1'b0;
    end
    else
    begin
      if (state == ST_CHECK && crc_bad) crc_error <= 1'b1; // see RULE_09
      if (state == ST_STARTUP && rise_ev && !stall && stage != LAST_STARTUP_CYCLE)
        stage <= stage + 3'd1; // see RULE_18
      if (state == ST_STARTUP && rise_ev && stage >= done_cycle && !stall)
        done_released <= 1'b1; // see RULE_10
    end
  end

  // pins; hold state floats every pin except par_address_o
  wire float_pins = (state == ST_HOLD); // see RULE_13
  assign pullups_on_o = float_pins && !pullup_disable_select_i;
  assign flash_select_n_o = !(state == ST_COMMAND || state == ST_LOAD);
  assign flash_select_oe_n_o = float_pins;
  assign config_clock_o = clk_level;
  assign config_clock_oe_n_o = float_pins;
  assign flash_cmd_o = shift_out[31];
  assign flash_cmd_oe_n_o = float_pins;
  assign chain_data_oe_n_o = float_pins;
  assign init_n_o = 1'b0;
  assign init_oe_n_o = !(state == ST_CLEAR || state == ST_ERROR); // see RULE_07
  assign done_o = 1'b0;
  assign done_oe_n_o = done_released || float_pins; // see RULE_10

  // axi register access
  wire [31:0] status_word = {17'h0_0000, done_pin, stage, addr_dir, variant, init_pin,
                             crc_error, done_released, state};
  logic [31:0] read_mux;
  always_comb
  begin
    case (ar_addr)
      OFS_CTRL: read_mux = {ctrl[31:CTRL_RESTART_BIT+1], 1'b0, ctrl[CTRL_RESTART_BIT-1:0]};
      OFS_LENGTH: read_mux = length;
      OFS_COMMAND: read_mux = command;
      OFS_CRC: read_mux = {16'h0000, crc_expect};
      OFS_LOCK_MASK: read_mux = 32'(lock_mask);
      OFS_STATUS: read_mux = status_word;
      OFS_PAR_ADDR: read_mux = {8'h00, par_address_o};
      OFS_SHIFT_WORD: read_mux = shift_in;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      ctrl <= CTRL_RESET;
      length <= LENGTH_RESET;
      command <= COMMAND_RESET;
      crc_expect <= '0;
      lock_mask <= '0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        case (aw_addr)
          OFS_CTRL: ctrl <= merge(ctrl, w_data, w_strb) & ~(32'h1 << CTRL_RESTART_BIT);
          OFS_LENGTH: length <= merge(length, w_data, w_strb);
          OFS_COMMAND: command <= merge(command, w_data, w_strb);
          OFS_CRC: crc_expect <= 16'(merge({16'h0000, crc_expect}, w_data, w_strb));
          OFS_LOCK_MASK: lock_mask <= LOCK_COUNT'(merge(32'(lock_mask), w_data, w_strb));
          default: ;
        endcase
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ar_pending <= 1'b0;
      ar_addr <= '0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end
    else
    begin
      ar_pending <= s_axi_arvalid_i && s_axi_arready_o;
      if (s_axi_arvalid_i && s_axi_arready_o) ar_addr <= s_axi_araddr_i;
      if (ar_pending)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= mapped(ar_addr) ? read_mux : 32'h0000_0000;
        s_axi_rresp_o <= mapped(ar_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule // serial_flash_config_loader

// file: sim/flash_loader_checker.sv
// assertion checker for the serial flash configuration loader
`timescale 1ns/100ps
module flash_loader_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // bus answers
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // flash link
  input wire logic flash_select_n_o,
  input wire logic flash_select_oe_n_o,
  input wire logic config_clock_o,
  input wire logic flash_cmd_o,
  input wire logic chain_data_o,
  // configuration pins
  input wire logic reprogram_n_i,
  input wire logic pullup_disable_select_i,
  input wire logic init_oe_n_o,
  input wire logic done_oe_n_o,
  input wire logic pullups_on_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_ONE_WR_RESP: assert property (
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  // eight cycles covers the pin synchroniser
  AST_NO_START: assert property (
    !reprogram_n_i [*8] |-> flash_select_n_o && init_oe_n_o)
    else $error("configuration started while reprogram low");
  AST_HOLD_FLOAT: assert property (
    !reprogram_n_i [*8] |-> flash_select_oe_n_o && done_oe_n_o)
    else $error("pins driven while reprogram low");
  AST_PULLUPS: assert property (
    pullups_on_o |-> flash_select_oe_n_o && !pullup_disable_select_i)
    else $error("pullups on while driving or disabled");
  AST_DONE_LOW_LOADING: assert property (
    !flash_select_n_o |-> !done_oe_n_o)
    else $error("done released during load");
  AST_INIT_FREE_AT_READ: assert property (
    $fell(flash_select_n_o) |-> init_oe_n_o)
    else $error("flash read began while init pulled");
  AST_CMD_ON_LOW_CLOCK: assert property (disable iff (sys_rst_i || !reprogram_n_i)
    $changed(flash_cmd_o) && !flash_select_n_o && $stable(flash_select_n_o) |-> !config_clock_o)
    else $error("command bit changed with clock high");
  AST_CLOCK_HALF: assert property (disable iff (sys_rst_i || !reprogram_n_i)
    $rose(config_clock_o) && !flash_select_n_o |=> config_clock_o [*3])
    else $error("config clock high phase too short");
  AST_CHAIN_ON_LOW_CLOCK: assert property (disable iff (sys_rst_i || !reprogram_n_i)
    $changed(chain_data_o) |-> !config_clock_o)
    else $error("chain data changed with clock high");
endmodule // flash_loader_checker

bind serial_flash_config_loader flash_loader_checker chk_u (.*);

// file: sim/flash_mem_model.sv
// serial flash memory model for the configuration loader bench
`timescale 1ns/100ps
module flash_mem_model #(
  parameter logic [31:0] PATTERN = 32'hC3A5_0F96
) (
  // flash link
  input wire logic config_clock_i,
  input wire logic select_n_i,
  input wire logic cmd_i,
  output logic data_o,
  // command word seen
  output logic [31:0] cmd_word_o
);
  int nbits = 0;
  logic [4:0] dcnt = 5'h00;

  initial
  begin
    data_o = 1'b0;
    cmd_word_o = 32'h0000_0000;
  end
  // command taken on rising edges, msb first
  always @(posedge config_clock_i or posedge select_n_i)
  begin
    if (select_n_i)
      nbits <= 0;
    else if (nbits < 32)
    begin
      cmd_word_o <= {cmd_word_o[30:0], cmd_i};
      nbits <= nbits + 1;
    end
  end
  // data on falling edges; released, the line toggles so no stale bit looks valid
  always @(negedge config_clock_i or posedge select_n_i)
  begin
    if (select_n_i)
    begin
      dcnt <= 5'h00;
      data_o <= ~data_o;
    end
    else if (nbits == 32)
    begin
      data_o <= PATTERN[5'h1F - dcnt];
      dcnt <= dcnt + 5'h01;
    end
  end
endmodule // flash_mem_model

// file: sim/serial_flash_config_loader_test.sv
// self-checking bench for the serial flash configuration loader
`timescale 1ns/100ps
module serial_flash_config_loader_test;
  import flash_loader_pkg::*;
  localparam logic [31:0] PATTERN = 32'hC3A5_0F96;
  localparam logic [31:0] CMD = 32'h0B12_3456;
  // half period 5 gives an 80 ns link clock
  localparam logic [31:0] CTRL_RUN = 32'h0001_A505;
  localparam logic [31:0] CTRL_LOCK = 32'h0001_A205;
  logic clk_i, sys_rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, cmd_seen, rd;
  logic [3:0] s_axi_wstrb_i, clock_manager_locked_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic flash_select_n_o, flash_select_oe_n_o, config_clock_o, config_clock_oe_n_o;
  logic flash_cmd_o, flash_cmd_oe_n_o, flash_data_i, chain_data_o, chain_data_oe_n_o;
  logic reprogram_n_i, pullup_disable_select_i, address_direction_pin_i, init_n_i;
  logic init_n_o, init_oe_n_o, done_i, done_o, done_oe_n_o, pullups_on_o, hold_init;
  logic [23:0] par_address_o;
  logic [2:0] variant_select_i;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  // open-drain pins with pull-ups
  assign init_n_i = init_oe_n_o && !hold_init;
  assign done_i = done_oe_n_o;

  // flash-attached master only; downstream slaves not modelled
  serial_flash_config_loader #(.CLEAR_CYCLES(4)) dut_u (.*);
  flash_mem_model #(.PATTERN(PATTERN)) flash_u (
    .config_clock_i(config_clock_o),
    .select_n_i(flash_select_n_o),
    .cmd_i(flash_cmd_o),
    .data_o(flash_data_i),
    .cmd_word_o(cmd_seen)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [15:0] crc_of(input logic [31:0] w, input int n);
    logic [15:0] c = CRC_SEED;
    for (int i = 0; i < n; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[31 - (i % 32)]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    forever
    begin
      @(posedge clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o)
        s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o)
        break;
    end
    s_axi_bready_i <= 1'b0;
    check(32'(s_axi_bresp_o), 32'(resp), "bresp");
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] resp);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    forever
    begin
      @(posedge clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o)
        s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o)
        break;
    end
    rd = s_axi_rdata_o;
    s_axi_rready_i <= 1'b0;
    check(32'(s_axi_rresp_o), 32'(resp), "rresp");
  endtask

  task automatic t_hold();
    repeat (5) @(posedge clk_i);
    check(32'({flash_select_oe_n_o, pullups_on_o}), 32'h3, "float");
    check(32'({flash_select_n_o, init_oe_n_o}), 32'h3, "no start");
    check(32'({init_n_o, done_o}), 32'h0, "open drain level");
    pullup_disable_select_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(32'(pullups_on_o), 32'h0, "pullups off");
    axi_rd(OFS_CTRL, RESP_OKAY);
    check(rd, CTRL_RESET, "ctrl reset");
    axi_rd(OFS_LENGTH, RESP_OKAY);
    check(rd, LENGTH_RESET, "length reset");
    axi_wr(8'h20, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_rd(8'h21, RESP_SLVERR);
    check(rd, 32'h0000_0000, "unmapped data");
    axi_wr(OFS_LENGTH, 32'h0000_0040, RESP_OKAY);
    axi_wr(OFS_COMMAND, CMD, RESP_OKAY);
    axi_wr(OFS_CRC, 32'(crc_of(PATTERN, 64)), RESP_OKAY);
    axi_wr(OFS_CTRL, CTRL_RUN, RESP_OKAY);
    $display("hold test done");
  endtask

  task automatic t_load();
    int n = 0;
    hold_init <= 1'b1;
    reprogram_n_i <= 1'b1;
    while (init_oe_n_o) @(posedge clk_i);
    while (!init_oe_n_o) @(posedge clk_i);
    repeat (40) @(posedge clk_i);
    check(32'(flash_select_n_o), 32'h1, "waits for init");
    hold_init <= 1'b0;
    while (flash_select_n_o) @(posedge clk_i);
    while (config_clock_o) @(posedge clk_i);
    while (!config_clock_o) @(posedge clk_i);
    do
    begin
      @(posedge clk_i);
      n++;
    end while (config_clock_o);
    check(32'(n), 32'h5, "half period");
    while (!done_oe_n_o) @(posedge clk_i);
    check(32'({flash_select_n_o, chain_data_oe_n_o, config_clock_oe_n_o, flash_cmd_oe_n_o}),
          32'h8, "pins after load");
    check(cmd_seen, CMD, "command");
    axi_rd(OFS_SHIFT_WORD, RESP_OKAY);
    check(rd, PATTERN, "bitstream");
    axi_rd(OFS_STATUS, RESP_OKAY);
    check(32'(rd[10:4]), 32'h2D, "status");
    $display("load test done");
  endtask

  task automatic t_lock();
    axi_wr(OFS_LOCK_MASK, 32'h0000_0001, RESP_OKAY);
    axi_wr(OFS_CTRL, CTRL_LOCK, RESP_OKAY);
    clock_manager_locked_i <= 4'h0;
    reprogram_n_i <= 1'b0;
    repeat (PROG_MIN_CYC + 1) @(posedge clk_i);
    check(32'(flash_select_oe_n_o), 32'h1, "float");
    reprogram_n_i <= 1'b1;
    while (flash_select_n_o) @(posedge clk_i);
    check(32'(done_oe_n_o), 32'h0, "done reset");
    while (!flash_select_n_o) @(posedge clk_i);
    repeat (300) @(posedge clk_i);
    axi_rd(OFS_STATUS, RESP_OKAY);
    check(32'({rd[13:11], done_oe_n_o}), 32'h4, "lock stall");
    clock_manager_locked_i <= 4'h1;
    while (!done_oe_n_o) @(posedge clk_i);
    $display("lock test done");
  endtask

  task automatic t_crc_bad();
    axi_wr(OFS_CRC, 32'(crc_of(PATTERN, 64) ^ 16'h0001), RESP_OKAY);
    axi_wr(OFS_CTRL, CTRL_RUN | 32'h0002_0000, RESP_OKAY);
    while (flash_select_n_o) @(posedge clk_i);
    while (!flash_select_n_o) @(posedge clk_i);
    repeat (40) @(posedge clk_i);
    check(32'({init_oe_n_o, done_oe_n_o}), 32'h0, "crc error");
    $display("crc test done");
  endtask

  task automatic t_par();
    logic [23:0] a;
    for (int dir = 0; dir < 2; dir++)
    begin
      address_direction_pin_i <= dir[0];
      axi_wr(OFS_CTRL, CTRL_RUN | 32'h0002_4000, RESP_OKAY);
      a = dir[0] ? 24'hFF_FFFE : 24'h00_0001;
      while (par_address_o !== a) @(posedge clk_i);
      while (par_address_o === a) @(posedge clk_i);
      check(32'(par_address_o), 32'(dir[0] ? a - 24'h1 : a + 24'h1), "step");
    end
    $display("parallel test done");
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    reprogram_n_i = 1'b0;
    hold_init = 1'b0;
    pullup_disable_select_i = 1'b0;
    variant_select_i = 3'h5;
    address_direction_pin_i = 1'b0;
    clock_manager_locked_i = 4'h0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
    {s_axi_arvalid_i, s_axi_rready_i} = 2'h0;
    s_axi_awaddr_i = 8'h00;
    s_axi_araddr_i = 8'h00;
    s_axi_wdata_i = 32'h0000_0000;
    s_axi_wstrb_i = 4'hF;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_hold();
    t_load();
    t_lock();
    t_crc_bad();
    t_par();
    end_sim();
  end
endmodule // serial_flash_config_loader_test
